// ==== inc/mac_check_cfg.svh ====
// Constants for the mac-check command unit
`ifndef MAC_CHECK_CFG_SVH
`define MAC_CHECK_CFG_SVH
`define OPC_MAC_CHECK   8'h28
`define MODE_RSVD_MASK  8'hF8
`define MODE_COPY_A     8'h01
`define MODE_COPY_B     8'h05
`define ZONE_CONFIG     2'h0
`define ZONE_OTP        2'h1
`define ZONE_DATA       2'h2
`define CFG_FIRST_WR    5'h04
`define CFG_EXTRA_WORD  5'h15
`define OTP_READ_ONLY   8'hAA
`define OTP_CONSUME     8'h55
`define WP_ALWAYS       4'h0
`define WP_ENCRYPT      4'h4
`define RKEY_NONE       4'h0
`define WDT_CYCLES_DEF  32'd25000000
`define WDT_MARGIN_DEF  32'd2000
`define RES_MATCH       8'h00
`define RES_MISMATCH    8'h01
`define ERR_PARSE       8'h03
`define ERR_EXEC        8'h0F
`define ERR_WDT         8'hEE
`define MSG_LAST        7'h57
`endif

// ==== inc/mac_check_pkg.sv ====
// Types shared by the mac-check command unit
package mac_check_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CHECK, ST_HASH, ST_WAIT, ST_CPY_FETCH, ST_CPY, ST_DONE
  } mac_state_e;
  typedef struct packed {
    logic [7:0]   opcode;
    logic [7:0]   mode;
    logic [15:0]  key_index;
    logic [255:0] client_challenge;
    logic [255:0] client_response;
    logic [103:0] extra_message_bytes;
  } mac_cmd_s;
  typedef struct packed {
    logic       require_random_nonce;
    logic       use_limited_flag;
    logic [3:0] slot_read_key_field;
  } slot_info_s;
  typedef struct packed {
    logic [1:0] zone;
    logic       write;
    logic       encrypted;
    logic       four_byte;
    logic [3:0] slot;
    logic [4:0] cfg_word;
  } zone_req_s;
  typedef struct packed {
    logic       config_locked;
    logic       otp_data_locked;
    logic [7:0] otp_lock_behaviour;
    logic       secret_slot_flag;
    logic       encrypted_read_flag;
    logic [3:0] slot_write_policy;
  } zone_pol_s;
endpackage

// ==== logic/zone_access_check.sv ====
// Zone select decode and read/write permission check
`timescale 1ns/1ps
`include "mac_check_cfg.svh"
module zone_access_check
  import mac_check_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire zone_req_s req,
  input  wire zone_pol_s pol,
  output logic           granted,
  output logic           bad_zone
);
  // ----------------------------------------
  // Permission decode
  // ----------------------------------------
  always_comb begin
    granted  = 1'b0;
    bad_zone = 1'b0;
    unique case (req.zone)
      `ZONE_CONFIG: begin
        // Low words and the extra bytes never take a plain write
        granted = !req.write || (!pol.config_locked && !req.encrypted &&
                  req.cfg_word >= `CFG_FIRST_WR && req.cfg_word != `CFG_EXTRA_WORD);
      end
      `ZONE_OTP: begin
        if (!req.write) begin
          granted = pol.otp_data_locked;
        end else begin
          granted = !pol.otp_data_locked || pol.otp_lock_behaviour == `OTP_CONSUME;
        end
      end
      `ZONE_DATA: begin
        if (!req.write) begin
          // Secret slots only leave the part encrypted, never as 4 bytes
          granted = pol.otp_data_locked && (!pol.secret_slot_flag ||
                    (pol.encrypted_read_flag && req.encrypted && !req.four_byte));
        end else begin
          granted = !pol.otp_data_locked || pol.slot_write_policy == `WP_ALWAYS ||
                    (pol.slot_write_policy == `WP_ENCRYPT && req.encrypted);
        end
      end
      default: bad_zone = 1'b1;
    endcase
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_otp_read_lock: assert property (req.zone == `ZONE_OTP && !req.write && !pol.otp_data_locked |-> !granted)
    else $error("otp read granted while unlocked");
  a_data_read_lock: assert property (req.zone == `ZONE_DATA && !req.write && !pol.otp_data_locked |-> !granted)
    else $error("data read granted while unlocked");
  a_cfg_write_lock: assert property (req.zone == `ZONE_CONFIG && req.write && pol.config_locked |-> !granted)
    else $error("config write granted while locked");
endmodule

// ==== logic/wake_watchdog.sv ====
// Wake watchdog that forces sleep a fixed count after wake
`timescale 1ns/1ps
`include "mac_check_cfg.svh"
module wake_watchdog
  import mac_check_pkg::*;
#(
  parameter logic [31:0] WDT_CYCLES = `WDT_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wake_token,
  input  wire logic        sleep_req,
  input  wire logic        idle_req,
  output logic             awake,
  output logic             expire,
  output logic [31:0]      remain
);
  logic [31:0] cnt_q;
  logic        awake_q;

  assign awake  = awake_q;
  assign expire = awake_q && cnt_q == WDT_CYCLES - 32'h1;
  assign remain = awake_q ? WDT_CYCLES - cnt_q : 32'h0;

  // ----------------------------------------
  // Awake state and counter
  // ----------------------------------------
  // A wake while awake is ignored: only sleep, idle or expiry restarts the count
  always_ff @(posedge mclk) begin
    if (rst || sleep_req || idle_req || expire) begin
      awake_q <= 1'b0;
    end else if (wake_token) begin
      awake_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !awake_q || sleep_req || idle_req || expire) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_wdt_expiry: assert property (awake_q && cnt_q == WDT_CYCLES - 32'h1 |=> !awake_q)
    else $error("watchdog did not force sleep");
  a_wdt_no_clear: assert property (awake_q && !sleep_req && !idle_req && !expire |=> cnt_q == $past(cnt_q) + 32'h1)
    else $error("watchdog count cleared while awake");
endmodule

// ==== logic/mac_check_unit.sv ====
// Mac-check command execution with zone checks and watchdog
`timescale 1ns/1ps
`include "mac_check_cfg.svh"
module mac_check_unit
  import mac_check_pkg::*;
#(
  parameter logic [31:0] WDT_CYCLES = `WDT_CYCLES_DEF,
  parameter logic [31:0] WDT_MARGIN = `WDT_MARGIN_DEF
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         wake_token,
  input  wire logic         sleep_req,
  input  wire logic         idle_req,
  output logic              awake,
  input  wire zone_req_s    zone_req,
  input  wire zone_pol_s    zone_pol,
  output logic              zone_granted,
  output logic              zone_bad,
  input  wire logic         cmd_valid,
  input  wire mac_cmd_s     cmd,
  output logic              cmd_ready,
  output logic [3:0]        slot_index,
  input  wire logic [255:0] slot_data,
  input  wire slot_info_s   slot_info,
  input  wire logic [71:0]  serial_number_bytes,
  input  wire logic         tk_load,
  input  wire logic [255:0] tk_value,
  input  wire logic         tk_from_rng,
  input  wire logic         seed_load,
  input  wire logic [255:0] seed_value,
  output logic [255:0]      temporary_key_register,
  output logic              nonce_origin_flag,
  output logic [255:0]      random_seed,
  output logic              authorization_valid_flag,
  output logic [3:0]        authorized_key_index,
  output logic              use_decrement,
  output logic              hash_valid,
  output logic [7:0]        hash_byte,
  output logic              hash_last,
  input  wire logic         hash_ready,
  input  wire logic         digest_valid,
  input  wire logic [255:0] digest,
  output logic              result_valid,
  output logic [7:0]        result_code
);
  mac_state_e   state_q;
  mac_cmd_s     cmd_q;
  logic [703:0] msg_q;
  logic [6:0]   cnt_q;
  logic [255:0] tk_q;
  logic         tk_rng_q;
  logic [255:0] seed_q;
  logic         auth_q;
  logic [3:0]   auth_idx_q;
  logic         dec_q;
  logic         res_v_q;
  logic [7:0]   res_q;
  logic         expire;
  logic [31:0]  remain;
  logic         go_sleep;
  logic         halt;
  logic         accept;
  logic         low_time;
  logic         bad_frame;
  logic         src_err;
  logic         rng_err;
  logic         match;
  logic         copy_mode;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] copy_target(input logic [3:0] key);
    copy_target = key[0] ? key : key + 4'h1;
  endfunction

  function automatic logic [255:0] pick32(input logic sel, input logic [255:0] a, input logic [255:0] b);
    pick32 = sel ? b : a;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  wake_watchdog #(
    .WDT_CYCLES (WDT_CYCLES)
  ) u_wdt (
    .mclk       (mclk),
    .rst        (rst),
    .wake_token (wake_token),
    .sleep_req  (sleep_req),
    .idle_req   (idle_req),
    .awake      (awake),
    .expire     (expire),
    .remain     (remain)
  );

  zone_access_check u_zone (
    .mclk     (mclk),
    .rst      (rst),
    .req      (zone_req),
    .pol      (zone_pol),
    .granted  (zone_granted),
    .bad_zone (zone_bad)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Expiry aborts work in flight, even mid-hash
  assign go_sleep  = expire || sleep_req;
  assign halt      = go_sleep || idle_req;
  assign cmd_ready = state_q == ST_IDLE && awake && !halt;
  assign accept    = cmd_valid && cmd_ready;
  assign low_time  = remain < WDT_MARGIN;
  // Full frame always taken; challenge kept even if unused
  assign bad_frame = cmd.opcode != `OPC_MAC_CHECK || (cmd.mode & `MODE_RSVD_MASK) != 8'h00;
  assign src_err   = (cmd_q.mode[1] || cmd_q.mode[0]) && cmd_q.mode[2] != tk_rng_q;
  assign rng_err   = !cmd_q.mode[1] && slot_info.require_random_nonce && !tk_rng_q;
  assign match     = digest == cmd_q.client_response;
  assign copy_mode = cmd_q.mode == `MODE_COPY_A || cmd_q.mode == `MODE_COPY_B;

  assign hash_valid = state_q == ST_HASH;
  assign hash_byte  = msg_q[703:696];
  assign hash_last  = cnt_q == `MSG_LAST;

  assign temporary_key_register   = tk_q;
  assign nonce_origin_flag        = tk_rng_q;
  assign random_seed              = seed_q;
  assign authorization_valid_flag = auth_q;
  assign authorized_key_index     = auth_idx_q;
  assign use_decrement            = dec_q;
  assign result_valid             = res_v_q;
  assign result_code              = res_q;

  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  // Slot data is expected one cycle after the index changes
  always_ff @(posedge mclk) begin
    if (rst || halt) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= (low_time || bad_frame) ? ST_DONE : ST_FETCH;
          end
        end
        ST_FETCH: state_q <= ST_CHECK;
        ST_CHECK: state_q <= (src_err || rng_err) ? ST_DONE : ST_HASH;
        ST_HASH: begin
          if (hash_ready && hash_last) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (digest_valid) begin
            state_q <= (match && copy_mode) ? ST_CPY_FETCH : ST_DONE;
          end
        end
        ST_CPY_FETCH: state_q <= ST_CPY;
        ST_CPY: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
    end else if (accept) begin
      cmd_q <= cmd;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_index <= 4'h0;
    end else if (accept) begin
      slot_index <= cmd.key_index[3:0];
    end else if (state_q == ST_WAIT && digest_valid) begin
      slot_index <= copy_target(cmd_q.key_index[3:0]);
    end
  end

  // Counted before hashing so an abort may still cost a use
  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_q <= 1'b0;
    end else begin
      dec_q <= state_q == ST_CHECK && !halt && !src_err && !rng_err &&
               !cmd_q.mode[1] && slot_info.use_limited_flag;
    end
  end

  // ----------------------------------------
  // Message assembly and streaming
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      msg_q <= '0;
    end else if (state_q == ST_CHECK) begin
      msg_q <= {pick32(cmd_q.mode[1], slot_data, tk_q),
                pick32(cmd_q.mode[0], cmd_q.client_challenge, tk_q),
                cmd_q.extra_message_bytes[103:72], 64'h0,
                cmd_q.extra_message_bytes[71:48], serial_number_bytes[7:0],
                cmd_q.extra_message_bytes[47:16], serial_number_bytes[71:56],
                cmd_q.extra_message_bytes[15:0]};
    end else if (hash_valid && hash_ready) begin
      msg_q <= {msg_q[695:0], 8'h00};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || state_q != ST_HASH) begin
      cnt_q <= 7'h0;
    end else if (hash_ready) begin
      cnt_q <= cnt_q + 7'h1;
    end
  end

  // ----------------------------------------
  // Result
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || go_sleep) begin
      res_q <= `RES_MATCH;
    end else if (accept) begin
      res_q <= low_time ? `ERR_WDT : (bad_frame ? `ERR_PARSE : `RES_MATCH);
    end else if (state_q == ST_CHECK && (src_err || rng_err)) begin
      res_q <= `ERR_EXEC;
    end else if (state_q == ST_WAIT && digest_valid) begin
      res_q <= match ? `RES_MATCH : `RES_MISMATCH;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      res_v_q <= 1'b0;
    end else begin
      res_v_q <= state_q == ST_DONE && !halt;
    end
  end

  // ----------------------------------------
  // Volatile registers
  // ----------------------------------------
  // Idle leaves both volatile registers untouched
  always_ff @(posedge mclk) begin
    if (rst || go_sleep) begin
      tk_q     <= '0;
      tk_rng_q <= 1'b0;
    end else if (tk_load && !idle_req) begin
      tk_q     <= tk_value;
      tk_rng_q <= tk_from_rng;
    end else if (state_q == ST_CPY && !idle_req &&
                 slot_info.slot_read_key_field == `RKEY_NONE) begin
      tk_q <= slot_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || go_sleep) begin
      seed_q <= '0;
    end else if (seed_load && !idle_req) begin
      seed_q <= seed_value;
    end
  end

  // Authorization is status, so idle drops it as sleep does
  always_ff @(posedge mclk) begin
    if (rst || halt) begin
      auth_q     <= 1'b0;
      auth_idx_q <= 4'h0;
    end else if (state_q == ST_WAIT && digest_valid && match && !cmd_q.mode[1]) begin
      auth_q     <= 1'b1;
      auth_idx_q <= cmd_q.key_index[3:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_dec_then_hash;
    use_decrement ##0 hash_valid;
  endsequence

  a_sleep_clears: assert property (go_sleep |=> tk_q == '0 && seed_q == '0 && !auth_q)
    else $error("sleep left volatile state");
  a_idle_keeps: assert property (idle_req && !go_sleep |=> tk_q == $past(tk_q) && seed_q == $past(seed_q))
    else $error("idle changed volatile state");
  a_wdt_refuse: assert property (accept && low_time |=> state_q == ST_DONE && res_q == `ERR_WDT)
    else $error("command started without watchdog time");
  a_parse_refuse: assert property (accept && !low_time && bad_frame |=> res_q == `ERR_PARSE)
    else $error("bad frame not refused");
  a_dec_first: assert property (state_q == ST_CHECK && !halt && !src_err && !rng_err && !cmd_q.mode[1] &&
                                slot_info.use_limited_flag |=> s_dec_then_hash)
    else $error("use count not taken before hash");
  a_src_flag: assert property (state_q == ST_CHECK && !halt && src_err
                               |=> res_q == `ERR_EXEC ##1 (res_v_q || $past(halt)))
    else $error("nonce origin mismatch not refused");
  a_auth_set: assert property (state_q == ST_WAIT && digest_valid && match && !cmd_q.mode[1] && !halt
                               |=> auth_q && auth_idx_q == $past(cmd_q.key_index[3:0]))
    else $error("authorization not recorded");
  a_result_byte: assert property (state_q == ST_WAIT && digest_valid && !match && !halt
                                  |=> res_q == `RES_MISMATCH ##1 (res_v_q || $past(halt)))
    else $error("mismatch not reported");
  a_msg_length: assert property (hash_valid && hash_ready && hash_last && !halt |=> state_q == ST_WAIT)
    else $error("message stream length wrong");
endmodule

// ==== verification/hash_slot_model.sv ====
// Far-side model: slot store and byte-fed digest engine
`timescale 1ns/1ps
module hash_slot_model (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic [3:0]   slot_index,
  input  wire logic         hash_valid,
  input  wire logic [7:0]   hash_byte,
  input  wire logic         hash_last,
  output logic              hash_ready,
  output logic [255:0]      slot_data,
  output logic              digest_valid,
  output logic [255:0]      digest,
  output logic [703:0]      msg_q
);
  logic [1:0]   wait_q;
  logic         busy_q;
  logic         tog_q;
  logic [255:0] fold;
  // ----------
  // Slot store and stalls
  // ----------
  // Contents carry the index so a wrong slot changes the digest
  assign slot_data  = {16{slot_index, 12'hC3A}};
  assign hash_ready = !slow || tog_q;
  // Key xor challenge; inverted while not valid so a stale value never matches
  assign fold   = msg_q[703:448] ^ msg_q[447:192];
  assign digest = digest_valid ? fold : ~fold;
  // ----------
  // Message capture
  // ----------
  always_ff @(posedge mclk) begin
    tog_q        <= !tog_q && !rst;
    digest_valid <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
    end else if (hash_valid && hash_ready) begin
      msg_q  <= {msg_q[695:0], hash_byte};
      busy_q <= hash_last;
      wait_q <= 2'h3;
    end else if (busy_q) begin
      wait_q       <= wait_q - 2'h1;
      busy_q       <= wait_q != 2'h0;
      digest_valid <= wait_q == 2'h0;
    end
  end
endmodule

// ==== verification/mac_check_unit_tb.sv ====
// Self-checking bench for the mac-check command unit
`timescale 1ns/1ps
module mac_check_unit_tb;
  import mac_check_pkg::*;
  localparam logic [31:0]  WDT = 32'd300;
  localparam logic [71:0]  SN  = 72'h0123456789ABCDEF42;
  localparam logic [103:0] XB  = 104'h1112131415161718191A1B1C1D;
  localparam logic [255:0] CH  = {8{32'h5A3C0F96}};
  localparam logic [255:0] TK  = {8{32'hE1D2C3B4}};
  logic         mclk, rst, wake_token, sleep_req, idle_req, awake, zone_granted, zone_bad;
  logic         cmd_valid, cmd_ready, tk_load, tk_from_rng, seed_load, nonce_origin_flag, slow;
  logic         authorization_valid_flag, use_decrement, hash_valid, hash_last, hash_ready;
  logic         digest_valid, result_valid;
  zone_req_s    zone_req;
  zone_pol_s    zone_pol;
  mac_cmd_s     cmd;
  slot_info_s   slot_info;
  logic [3:0]   slot_index, authorized_key_index;
  logic [255:0] slot_data, tk_value, temporary_key_register, random_seed, digest;
  logic [7:0]   hash_byte, result_code, rc;
  logic [703:0] msg;
  int           n_fail = 0, tests_run = 0, cyc = 0, n_dec = 0, n, d0;

  mac_check_unit #(.WDT_CYCLES(WDT), .WDT_MARGIN(32'd20)) dut_u (
    .mclk, .rst, .wake_token, .sleep_req, .idle_req, .awake, .zone_req, .zone_pol, .zone_granted,
    .zone_bad, .cmd_valid, .cmd, .cmd_ready, .slot_index, .slot_data, .slot_info,
    .serial_number_bytes(SN), .tk_load, .tk_value, .tk_from_rng, .seed_load, .seed_value(CH),
    .temporary_key_register, .nonce_origin_flag, .random_seed, .authorization_valid_flag,
    .authorized_key_index, .use_decrement, .hash_valid, .hash_byte, .hash_last, .hash_ready,
    .digest_valid, .digest, .result_valid, .result_code);
  hash_slot_model pm_u (.mclk, .rst, .slow, .slot_index, .hash_valid, .hash_byte, .hash_last,
    .hash_ready, .slot_data, .digest_valid, .digest, .msg_q(msg));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole run needs about 1600 cycles
  always @(posedge mclk) begin
    cyc++;
    n_dec += use_decrement;
    if (cyc == 6000) begin
      n_fail++;
      finish_test();
    end
  end
  // ----------
  // Tasks
  // ----------
  function automatic logic [255:0] sd(input logic [3:0] k);
    sd = {16{k, 12'hC3A}};
  endfunction
  function automatic logic [703:0] exp_msg(input logic [255:0] k, c);
    exp_msg = {k, c, XB[103:72], 64'h0, XB[71:48], SN[7:0], XB[47:16], SN[71:56], XB[15:0]};
  endfunction
  task automatic chk(input string nm, input logic [703:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Bits: wake, sleep, idle, temp key load, seed load
  task automatic strobe(input logic [4:0] s);
    @(posedge mclk);
    {wake_token, sleep_req, idle_req, tk_load, seed_load} <= s;
    @(posedge mclk);
    {wake_token, sleep_req, idle_req, tk_load, seed_load} <= 5'h00;
  endtask
  // Idle then wake keeps the temporary key while restarting the watchdog
  task automatic issue(input logic [7:0] op, md, input logic [3:0] k, input logic [255:0] rsp);
    strobe(5'b00100);
    strobe(5'b10000);
    n = 0;
    @(posedge mclk);
    cmd       <= '{op, md, {12'h000, k}, CH, rsp, XB};
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1 && ++n < 99);
    cmd_valid <= 1'b0;
    do @(posedge mclk); while (result_valid !== 1'b1 && ++n < 999);
    chk("result_valid", 1, result_valid);
    rc = result_code;
  endtask
  task automatic zchk(input logic [1:0] z, input logic w, lk, input logic [7:0] ob,
                      input logic [3:0] wp, input logic e);
    @(posedge mclk);
    zone_req <= '{z, w, 1'b0, 1'b0, 4'h3, 5'h08};
    zone_pol <= '{lk, lk, ob, 1'b0, 1'b0, wp};
    @(posedge mclk);
    chk("zone_granted", e, zone_granted);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    {rst, wake_token, sleep_req, idle_req, tk_load, tk_from_rng, seed_load, cmd_valid, slow} = 9'h100;
    zone_req  = '0;
    zone_pol  = '0;
    cmd       = '0;
    slot_info = '0;
    tk_value  = TK;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("awake", 0, awake);
    chk("result_code", 0, result_code);
    zchk(2'h0, 1'b0, 1'b1, 8'hAA, 4'h0, 1'b1);
    zchk(2'h0, 1'b1, 1'b0, 8'hAA, 4'h0, 1'b1);
    zchk(2'h0, 1'b1, 1'b1, 8'hAA, 4'h0, 1'b0);
    zchk(2'h1, 1'b0, 1'b0, 8'hAA, 4'h0, 1'b0);
    zchk(2'h1, 1'b0, 1'b1, 8'hAA, 4'h0, 1'b1);
    zchk(2'h1, 1'b1, 1'b0, 8'hAA, 4'h0, 1'b1);
    zchk(2'h1, 1'b1, 1'b1, 8'hAA, 4'h0, 1'b0);
    zchk(2'h1, 1'b1, 1'b1, 8'h55, 4'h0, 1'b1);
    zchk(2'h2, 1'b0, 1'b0, 8'hAA, 4'h0, 1'b0);
    zchk(2'h2, 1'b0, 1'b1, 8'hAA, 4'h0, 1'b1);
    zchk(2'h2, 1'b1, 1'b0, 8'hAA, 4'h1, 1'b1);
    zchk(2'h2, 1'b1, 1'b1, 8'hAA, 4'h0, 1'b1);
    zchk(2'h2, 1'b1, 1'b1, 8'hAA, 4'h1, 1'b0);
    zchk(2'h3, 1'b0, 1'b1, 8'hAA, 4'h0, 1'b0);
    chk("zone_bad", 1, zone_bad);
    // Locked secret slot with encrypted reads, encrypted-only write policy
    zone_pol <= '{1'b1, 1'b1, 8'hAA, 1'b1, 1'b1, 4'h4};
    for (int i = 0; i < 4; i++) begin
      zone_req <= '{2'h2, i[1], i[0], 1'b0, 4'h3, 5'h08};
      repeat (2) @(posedge mclk);
      chk("zone_granted", i[0], zone_granted);
    end
    chk("zone_bad", 0, zone_bad);
    issue(8'h27, 8'h00, 4'h6, CH);
    chk("result_code", 8'h03, rc);
    issue(8'h28, 8'h08, 4'h6, CH);
    chk("result_code", 8'h03, rc);
    // Limited-use slot key, nonce already loaded
    slot_info <= '{1'b0, 1'b1, 4'h0};
    strobe(5'b00010);
    d0 = n_dec;
    issue(8'h28, 8'h00, 4'h6, sd(4'h6) ^ CH);
    chk("result_code", 8'h00, rc);
    chk("message", exp_msg(sd(4'h6), CH), msg);
    chk("auth_flag", 1, authorization_valid_flag);
    chk("auth_index", 4'h6, authorized_key_index);
    chk("use_count", 1, n_dec - d0);
    slow <= 1'b1;
    issue(8'h28, 8'h00, 4'h6, CH);
    chk("result_code", 8'h01, rc);
    slot_info   <= '{1'b0, 1'b0, 4'h0};
    tk_from_rng <= 1'b1;
    strobe(5'b00010);
    issue(8'h28, 8'h07, 4'h6, 256'h0);
    chk("result_code", 8'h00, rc);
    chk("message", exp_msg(TK, TK), msg);
    chk("nonce_origin", 1, nonce_origin_flag);
    issue(8'h28, 8'h03, 4'h6, 256'h0);
    chk("result_code", 8'h0F, rc);
    slot_info   <= '{1'b1, 1'b0, 4'h0};
    tk_from_rng <= 1'b0;
    strobe(5'b00010);
    issue(8'h28, 8'h00, 4'h6, sd(4'h6) ^ CH);
    chk("result_code", 8'h0F, rc);
    slot_info <= '{1'b0, 1'b0, 4'h0};
    for (int i = 0; i < 2; i++) begin
      tk_from_rng <= i[0];
      strobe(5'b00010);
      issue(8'h28, i ? 8'h05 : 8'h01, i ? 4'h7 : 4'h4, sd(i ? 4'h7 : 4'h4) ^ TK);
      chk("temp_key", sd(i ? 4'h7 : 4'h5), temporary_key_register);
    end
    strobe(5'b00011);
    strobe(5'b00100);
    strobe(5'b10000);
    @(posedge mclk);
    chk("temp_key", TK, temporary_key_register);
    chk("seed", CH, random_seed);
    strobe(5'b01000);
    repeat (2) @(posedge mclk);
    chk("seed", 0, random_seed);
    // A second wake token mid-run must not restart the count
    strobe(5'b10000);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      wake_token <= (n == 50);
      tk_load    <= (n == 10);
    end while (awake === 1'b1 && n < 999);
    // The poll that sees awake low comes one edge after the last awake cycle
    chk("awake_cycles", WDT, n - 1);
    chk("temp_key", 0, temporary_key_register);
    chk("nonce_origin", 0, nonce_origin_flag);
    strobe(5'b10000);
    // Leaves 15 cycles, under the 20-cycle margin
    repeat (285) @(posedge mclk);
    n = 0;
    cmd       <= '{8'h28, 8'h00, 16'h0006, CH, CH, XB};
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1 && ++n < 9);
    cmd_valid <= 1'b0;
    do @(posedge mclk); while (result_valid !== 1'b1 && ++n < 9);
    chk("result_valid", 1, result_valid);
    chk("result_code", 8'hEE, result_code);
    finish_test();
  end
endmodule
